// *** rtl/csr_consts.vh ***
// Purpose: Shared constants of the cassette serial inline router
// Assumes: 50 MHz system clock
// Notes: Register offsets are byte addresses on a 32-bit Avalon-MM slave
`ifndef CSR_CONSTS_VH
`define CSR_CONSTS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CSR_OFF_CTRL 4'h0
`define CSR_OFF_STATUS 4'h4
`define CSR_OFF_ACTIVITY 4'h8

// CTRL fields
`define CSR_CTRL_LOCAL 0
`define CSR_CTRL_INVERT 1
`define CSR_CTRL_REC_SET 2
`define CSR_CTRL_REC_CLR 3
`define CSR_CTRL_RD_SET 4
`define CSR_CTRL_RD_CLR 5
`define CSR_CTRL_RESET 2'h0

// STATUS fields
`define CSR_ST_REC 0
`define CSR_ST_RD 1
`define CSR_ST_REC_ACT 2
`define CSR_ST_RD_ACT 3
`define CSR_ST_CARRIER 4
`define CSR_ST_LOCAL 5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CSR_CLK_HZ 50000000
`define CSR_ACT_HOLD_MS 20
`define CSR_ACT_HOLD_CYC ((`CSR_CLK_HZ / 1000) * `CSR_ACT_HOLD_MS)
`define CSR_BAUD 300
`define CSR_OVERSAMPLE 16
`define CSR_FIFO_DEPTH 8

`endif

// *** rtl/csr_fifo.v ***
// Purpose: Small valid/ready FIFO for tape bits toward the host, or toward the terminal in local mode
// Assumes: Single clock, synchronous reset
// Notes: Depth must be a power of two
`timescale 1ns/10ps

module csr_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW:0] wr_ptr;
reg [AW:0] rd_ptr;
wire [AW:0] level;

assign level = wr_ptr - rd_ptr;
assign in_ready = (level != DEPTH[AW:0]);
assign out_valid = (level != {(AW+1){1'b0}});
assign out_data = mem[rd_ptr[AW-1:0]];

// Pointer and storage update
always @(posedge clock) begin
    if (rst) begin
        wr_ptr <= {(AW+1){1'b0}};
        rd_ptr <= {(AW+1){1'b0}};
    end else begin
        if (in_valid && in_ready) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
            wr_ptr <= wr_ptr + 1'b1;
        end
        if (out_valid && out_ready)
            rd_ptr <= rd_ptr + 1'b1;
    end
end

endmodule // csr_fifo

// *** rtl/csr_router.v ***
// Purpose: Inline router between host and terminal serial lines with tape copy and injection
// Assumes: Terminal 16X baud clock and command strobes arrive asynchronously
// Notes: Tones are made and detected outside; this block sees logic-level bit streams
`timescale 1ns/10ps
`include "csr_consts.vh"

module csr_router #(
    parameter ACT_HOLD = `CSR_ACT_HOLD_CYC,
    parameter FIFO_DEPTH = `CSR_FIFO_DEPTH,
    parameter FIFO_AW = 3
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Avalon-MM slave
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Host serial port
    input wire host_txd,
    output reg host_rxd,
    // Terminal serial port
    input wire term_txd,
    output reg term_rxd,
    input wire term_clk16,
    // Terminal command strobes
    input wire cmd_read_on,
    input wire cmd_read_off,
    input wire cmd_rec_on,
    input wire cmd_rec_off,
    input wire cmd_invert_n,
    // Front panel
    input wire sw_local,
    input wire sw_rec_set,
    input wire sw_rec_clr,
    // Tape side
    output reg tape_out,
    input wire tape_in,
    input wire tape_carrier,
    // Indicators
    output reg led_rec_status,
    output reg led_rec_act,
    output reg led_rd_status,
    output reg led_rd_act
);

// ----------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------
// Every serial, tape, strobe and switch pin crosses from a foreign clock, so each one gets three flops.
// Presetting the chain to mark keeps the lines idle while reset is high,
// which is also the inactive level of the default low-going strobes.
// Bit 0 is a spare tied high so the vector stays a round number.
localparam NSYNC = 14;
wire [NSYNC-1:0] raw_in;
reg [NSYNC-1:0] sync1;
reg [NSYNC-1:0] sync2;
reg [NSYNC-1:0] sync3;
reg [NSYNC-1:0] clean;

assign raw_in = {sw_rec_clr, sw_rec_set, sw_local, cmd_invert_n, cmd_rec_off, cmd_rec_on,
                 cmd_read_off, cmd_read_on, tape_carrier, tape_in, term_clk16, term_txd,
                 host_txd, 1'b1};

// A change counts once the last two stages agree; filters one-edge glitches
always @(posedge clock) begin
    if (rst) begin
        sync1 <= {NSYNC{1'b1}};
        sync2 <= {NSYNC{1'b1}};
        sync3 <= {NSYNC{1'b1}};
        clean <= {NSYNC{1'b1}};
    end else begin
        sync1 <= raw_in;
        sync2 <= sync1;
        sync3 <= sync2;
        clean <= (sync2 & sync3) | (clean & (sync2 | sync3));
    end
end

wire s_host_txd = clean[1];
wire s_term_txd = clean[2];
wire s_clk16 = clean[3];
wire s_tape_in = clean[4];
wire s_carrier = clean[5];
wire s_local = clean[11];
wire s_sw_set = clean[12];
wire s_sw_clr = clean[13];

// ----------------------------------------------------------------
// Command strobe decode
// ----------------------------------------------------------------
// Strobes are active low unless invert input is grounded
wire pol_high = ~clean[10];
wire [3:0] cmd_act = pol_high ? clean[9:6] : ~clean[9:6];
reg [3:0] cmd_prev;
wire [3:0] cmd_rise = cmd_act & ~cmd_prev;

// Strobes last 1 to 1000 us, far longer than a clock, so a plain edge
// detector sees each one exactly once; width is not policed here.
// Switch edges, not levels, move the record latch so a switch left up
// does not fight the terminal's record-off command.
// Edge detectors preset to mark to match the preset synchronisers,
// otherwise the first edge after reset would look like a switch flip.
// Front-panel switch edges
reg sw_set_prev;
reg sw_clr_prev;
wire sw_set_rise = s_sw_set & ~sw_set_prev;
wire sw_clr_rise = s_sw_clr & ~sw_clr_prev;

// ----------------------------------------------------------------
// Software control register
// ----------------------------------------------------------------
reg ctrl_local;
reg ctrl_invert_unused;
reg sw_rec_set_p;
reg sw_rec_clr_p;
reg sw_rd_set_p;
reg sw_rd_clr_p;
// Register writes produce one-cycle pulses for the latch set/clear bits;
// only the local bit and the spare bit are stored and read back.
// A write and a read are never both high, so one decode serves both.
// Unmapped offsets read zero and ignore writes.
wire bus_wr = avs_write && !avs_waitrequest;
wire bus_rd = avs_read && !avs_waitrequest;

// Writes take effect on the edge that sees waitrequest low
always @(posedge clock) begin
    if (rst) begin
        ctrl_local <= 1'b0;
        ctrl_invert_unused <= 1'b0;
        sw_rec_set_p <= 1'b0;
        sw_rec_clr_p <= 1'b0;
        sw_rd_set_p <= 1'b0;
        sw_rd_clr_p <= 1'b0;
    end else begin
        sw_rec_set_p <= 1'b0;
        sw_rec_clr_p <= 1'b0;
        sw_rd_set_p <= 1'b0;
        sw_rd_clr_p <= 1'b0;
        if (bus_wr && avs_address == `CSR_OFF_CTRL) begin
            ctrl_local <= avs_writedata[`CSR_CTRL_LOCAL];
            ctrl_invert_unused <= avs_writedata[`CSR_CTRL_INVERT];
            sw_rec_set_p <= avs_writedata[`CSR_CTRL_REC_SET];
            sw_rec_clr_p <= avs_writedata[`CSR_CTRL_REC_CLR];
            sw_rd_set_p <= avs_writedata[`CSR_CTRL_RD_SET];
            sw_rd_clr_p <= avs_writedata[`CSR_CTRL_RD_CLR];
        end
    end
end

// Local mode from the panel switch or from software
wire local_mode = s_local | ctrl_local;

// ----------------------------------------------------------------
// Status latches
// ----------------------------------------------------------------
reg rec_latch;
reg rd_latch;
wire rec_set = cmd_rise[2] | sw_set_rise | sw_rec_set_p;
wire rec_clr = cmd_rise[3] | sw_clr_rise | sw_rec_clr_p;
wire rd_set = cmd_rise[0] | sw_rd_set_p;
wire rd_clr = cmd_rise[1] | sw_rd_clr_p;

// The terminal can send record-on and record-off in quick succession;
// giving set priority means a racing pair leaves the latch on, which
// costs some tape but never loses data the host meant to keep.
// Set wins over a clear in the same cycle so a set is never lost
always @(posedge clock) begin
    if (rst) begin
        cmd_prev <= 4'h0;
        sw_set_prev <= 1'b1;
        sw_clr_prev <= 1'b1;
        rec_latch <= 1'b0;
        rd_latch <= 1'b0;
    end else begin
        cmd_prev <= cmd_act;
        sw_set_prev <= s_sw_set;
        sw_clr_prev <= s_sw_clr;
        if (rec_set)
            rec_latch <= 1'b1;
        else if (rec_clr)
            rec_latch <= 1'b0;
        if (rd_set)
            rd_latch <= 1'b1;
        else if (rd_clr)
            rd_latch <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Tape bit path through FIFO, paced by the 16X clock
// ----------------------------------------------------------------
// Tape data enters only with read latch on and carrier present
wire tape_gate = rd_latch & s_carrier;
// The 16X clock is sampled like any pin, so it must stay well below
// half the system clock; at a few kilohertz the margin is enormous.
// Edge detector preset to match the synchroniser's mark preset.
reg clk16_prev;
wire clk16_rise = s_clk16 & ~clk16_prev;
reg [3:0] div16;
wire bit_tick = clk16_rise && div16 == 4'hf;
wire fifo_in_ready;
wire fifo_out_valid;
wire fifo_out_data;
reg drain_tick;

// Samples tape at 16X rate; a sample refused by a full FIFO is dropped, not held
always @(posedge clock) begin
    if (rst) begin
        clk16_prev <= 1'b1;
        div16 <= 4'h0;
        drain_tick <= 1'b0;
    end else begin
        clk16_prev <= s_clk16;
        drain_tick <= clk16_rise;
        if (clk16_rise)
            div16 <= div16 + 4'h1;
    end
end

// The FIFO only smooths the one-cycle skew between fill and drain;
// it cannot overflow since both sides run on the same 16X edge.
csr_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(tape_gate && clk16_rise),
    .in_ready(fifo_in_ready),
    .in_data(s_tape_in),
    .out_valid(fifo_out_valid),
    .out_ready(drain_tick),
    .out_data(fifo_out_data)
);

// Held tape bit, idle mark while the read gate is closed; holds last bit when nothing is queued
reg tape_bit;
always @(posedge clock) begin
    if (rst)
        tape_bit <= 1'b1;
    else if (!tape_gate)
        tape_bit <= 1'b1;
    else if (fifo_out_valid && drain_tick)
        tape_bit <= fifo_out_data;
end

// ----------------------------------------------------------------
// Activity stretchers
// ----------------------------------------------------------------
// Counter width fits the default hold of one million cycles;
// a longer hold needs a wider counter.
localparam CW = 20;
reg [CW-1:0] rec_cnt;
reg [CW-1:0] rd_cnt;
wire line_space = local_mode ? ~s_term_txd : (~s_term_txd | ~s_host_txd);

// Space bits retrigger a hold so the light visibly flickers
always @(posedge clock) begin
    if (rst) begin
        rec_cnt <= {CW{1'b0}};
        rd_cnt <= {CW{1'b0}};
    end else begin
        if (rec_latch && line_space)
            rec_cnt <= ACT_HOLD[CW-1:0];
        else if (!rec_latch)
            rec_cnt <= {CW{1'b0}};
        else if (rec_cnt != {CW{1'b0}})
            rec_cnt <= rec_cnt - 1'b1;
        if (tape_gate && !tape_bit)
            rd_cnt <= ACT_HOLD[CW-1:0];
        else if (!tape_gate)
            rd_cnt <= {CW{1'b0}};
        else if (rd_cnt != {CW{1'b0}})
            rd_cnt <= rd_cnt - 1'b1;
    end
end

// ----------------------------------------------------------------
// Routing and outputs
// ----------------------------------------------------------------
// Read data is decoded from live state and registered during the
// wait cycle, so it is stable when waitrequest drops.
reg [31:0] next_readdata;
always @* begin
    next_readdata = 32'h0;
    case (avs_address)
        `CSR_OFF_CTRL: next_readdata = {30'h0, ctrl_invert_unused, ctrl_local};
        `CSR_OFF_STATUS: next_readdata = {26'h0, local_mode, s_carrier, led_rd_act,
                                          led_rec_act, rd_latch, rec_latch};
        `CSR_OFF_ACTIVITY: next_readdata = {31'h0, fifo_in_ready};
        default: next_readdata = 32'h0;
    endcase
end

// All outputs are registered so the pins never glitch while the
// routing mux changes between local and remote mode.
// Host in remote mode, or display in local mode, sees tape bits ANDed in: a space from either side
// wins, matching how two open-collector line drivers would combine.
// One wait cycle per access, then one ready cycle
always @(posedge clock) begin
    if (rst) begin
        avs_waitrequest <= 1'b1;
        avs_readdata <= 32'h0;
        host_rxd <= 1'b1;
        term_rxd <= 1'b1;
        tape_out <= 1'b1;
        led_rec_status <= 1'b0;
        led_rec_act <= 1'b0;
        led_rd_status <= 1'b0;
        led_rd_act <= 1'b0;
    end else begin
        avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        if (avs_read && avs_waitrequest)
            avs_readdata <= next_readdata;
        if (local_mode) begin
            host_rxd <= 1'b1;
            term_rxd <= s_term_txd & tape_bit;
        end else begin
            host_rxd <= s_term_txd & tape_bit;
            term_rxd <= s_host_txd;
        end
        // Line traffic copied only while record latch set
        tape_out <= rec_latch ? (local_mode ? s_term_txd : (s_term_txd & s_host_txd)) : 1'b1;
        led_rec_status <= rec_latch;
        led_rd_status <= rd_latch;
        led_rec_act <= rec_cnt != {CW{1'b0}};
        led_rd_act <= rd_cnt != {CW{1'b0}};
    end
end

endmodule // csr_router

// *** tb/csr_router_monitor.sv ***
// Purpose: Port checks of the inline router
// Assumes: One clock domain, sync reset
// Notes: Ranges allow for the input synchronisers
`timescale 1ns/10ps
module csr_router_monitor (
    // Clock and reset
    input logic clock,
    input logic rst,
    // Bus
    input logic avs_read,
    input logic avs_write,
    input logic avs_waitrequest,
    // Lines
    input logic host_txd,
    input logic host_rxd,
    input logic term_txd,
    input logic term_rxd,
    input logic tape_out,
    // Strobes and switches
    input logic cmd_read_on,
    input logic cmd_read_off,
    input logic cmd_rec_on,
    input logic cmd_rec_off,
    input logic cmd_invert_n,
    input logic sw_local,
    // Indicators
    input logic led_rec_status,
    input logic led_rec_act,
    input logic led_rd_status,
    input logic led_rd_act
);
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    chk_bus_answer: assert property ($rose(avs_read || avs_write) |-> ##[1:2] !avs_waitrequest)
        else $error("bus answer late");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    chk_idle_wait: assert property (!(avs_read || avs_write) [*2] |-> avs_waitrequest)
        else $error("waitrequest low at idle");
    chk_rec_on_cmd: assert property ((cmd_invert_n ? $fell(cmd_rec_on) : $rose(cmd_rec_on)) |-> ##[1:10] led_rec_status)
        else $error("record latch not set");
    chk_rec_off_cmd: assert property ((cmd_invert_n ? $fell(cmd_rec_off) : $rose(cmd_rec_off)) |-> ##[1:10] !led_rec_status)
        else $error("record latch not cleared");
    chk_rd_on_cmd: assert property ((cmd_invert_n ? $fell(cmd_read_on) : $rose(cmd_read_on)) |-> ##[1:10] led_rd_status)
        else $error("read latch not set");
    chk_rd_off_cmd: assert property ((cmd_invert_n ? $fell(cmd_read_off) : $rose(cmd_read_off)) |-> ##[1:10] !led_rd_status)
        else $error("read latch not cleared");
    chk_rec_idle: assert property (!led_rec_status [*2] |-> tape_out)
        else $error("tape written while record clear");
    chk_local_loop: assert property ((sw_local && !led_rd_status && $stable(term_txd)) [*8] |-> term_rxd == term_txd)
        else $error("local loop broken");
    chk_remote_path: assert property ((!sw_local && !led_rd_status && $stable(host_txd) && $stable(term_txd)) [*8]
        |-> term_rxd == host_txd && host_rxd == term_txd)
        else $error("remote path broken");
    // Main scenarios reached
    cover property (led_rd_act && !host_rxd);
    cover property (led_rec_act && !tape_out);
    cover property (sw_local && !term_rxd);
endmodule // csr_router_monitor

// *** tb/csr_router_tb_top.sv ***
// Purpose: Self-checking bench of the inline router
// Assumes: 50 MHz clock, short activity hold
// Notes: Strobe bits 0..3 are read on, read off, record on, record off
`timescale 1ns/10ps
module csr_router_tb_top;
    logic clock = 0;
    logic rst = 1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 0, avs_write = 0, avs_waitrequest;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic host_txd = 1, host_rxd, term_txd = 1, term_rxd, term_clk16, tape_out;
    logic [3:0] cmd = 4'hf;
    logic cmd_invert_n = 1, sw_local = 0, sw_rec_set = 0, sw_rec_clr = 0, tape_in = 1, tape_carrier = 0;
    logic led_rec_status, led_rec_act, led_rd_status, led_rd_act;
    int err_count = 0, total_checks = 0, cyc = 0;

    // ----------------------------------------------------------------
    // Clock, partner and design
    // ----------------------------------------------------------------
    always #10 clock = ~clock;
    csr_term_model TERM (.clk16(term_clk16));
    csr_router #(.ACT_HOLD(16)) DUT (.clock(clock), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .host_txd(host_txd),
        .host_rxd(host_rxd), .term_txd(term_txd), .term_rxd(term_rxd), .term_clk16(term_clk16),
        .cmd_read_on(cmd[0]), .cmd_read_off(cmd[1]), .cmd_rec_on(cmd[2]), .cmd_rec_off(cmd[3]),
        .cmd_invert_n(cmd_invert_n), .sw_local(sw_local), .sw_rec_set(sw_rec_set),
        .sw_rec_clr(sw_rec_clr), .tape_out(tape_out), .tape_in(tape_in), .tape_carrier(tape_carrier),
        .led_rec_status(led_rec_status), .led_rec_act(led_rec_act), .led_rd_status(led_rd_status),
        .led_rd_act(led_rd_act));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Held until waitrequest is sampled low; the timeout ends a hang
    task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
        avs_address <= ad;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
        @(posedge clock);
    endtask
    // Strobe of 1.2 us, inside the allowed width
    task automatic pulse(input int k);
        cmd[k] <= ~cmd[k];
        wt(60);
        cmd[k] <= ~cmd[k];
        wt(20);
    endtask
    task automatic close_out();
        if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_path();
        host_txd <= 0;
        wt(12);
        chk("term_rxd", term_rxd, 0);
        chk("host_rxd", host_rxd, 1);
        chk("tape_out", tape_out, 1);
        host_txd <= 1;
        term_txd <= 0;
        wt(12);
        chk("host_rxd", host_rxd, 0);
        chk("term_rxd", term_rxd, 1);
        term_txd <= 1;
        wt(12);
    endtask
    task automatic t_local();
        sw_local <= 1;
        host_txd <= 0;
        term_txd <= 0;
        wt(12);
        chk("loop", term_rxd, 0);
        chk("host_cut", host_rxd, 1);
        sw_rec_set <= 1;
        wt(12);
        chk("rec_sw", led_rec_status, 1);
        chk("rec_copy", tape_out, 0);
        sw_rec_set <= 0;
        sw_rec_clr <= 1;
        wt(12);
        chk("rec_sw", led_rec_status, 0);
        chk("rec_idle", tape_out, 1);
        {sw_rec_clr, sw_local, host_txd, term_txd} <= 4'h3;
        wt(12);
    endtask
    // Both strobe polarities; a polarity change may look like a strobe, so clear first
    task automatic t_cmds();
        for (int p = 0; p < 3; p++) begin
            cmd_invert_n <= (p != 1);
            cmd <= {4{p != 1}};
            wt(12);
            pulse(3);
            pulse(1);
            if (p == 2) break;
            pulse(2);
            chk("rec_on", led_rec_status, 1);
            host_txd <= 0;
            wt(12);
            chk("rec_copy", tape_out, 0);
            chk("rec_act", led_rec_act, 1);
            pulse(3);
            chk("rec_off", led_rec_status, 0);
            chk("rec_gate", tape_out, 1);
            host_txd <= 1;
            pulse(0);
            chk("rd_on", led_rd_status, 1);
            pulse(1);
            chk("rd_off", led_rd_status, 0);
        end
    endtask
    task automatic t_read();
        int i;
        pulse(0);
        tape_in <= 0;
        wt(40);
        chk("rd_hold", host_rxd, 1);
        chk("rd_act", led_rd_act, 0);
        tape_carrier <= 1;
        i = 0;
        while (host_rxd !== 1'b0 && i < 400) begin
            @(posedge clock);
            i++;
        end
        chk("rd_pass", host_rxd, 0);
        wt(4);
        chk("rd_act", led_rd_act, 1);
        pulse(1);
        wt(200);
        chk("rd_ignore", host_rxd, 1);
        tape_in <= 1;
        tape_carrier <= 0;
        wt(12);
    endtask
    task automatic t_regs();
        bus(1, 4'h0, 32'h11);
        bus(0, 4'h0, 0);
        chk("ctrl", q, 32'h1);
        bus(0, 4'h4, 0);
        chk("status", q, 32'h22);
        bus(1, 4'h0, 32'h20);
        bus(0, 4'h4, 0);
        chk("status", q, 32'h0);
        bus(1, 4'hc, 32'hff);
        bus(0, 4'hc, 0);
        chk("unmapped", q, 32'h0);
        bus(0, 4'h8, 0);
        chk("fifo_room", q, 32'h1);
    endtask

    // Main sequence
    initial begin
        wt(16);
        rst <= 0;
        wt(8);
        t_path();
        t_local();
        t_cmds();
        t_read();
        t_regs();
        close_out();
    end
    // Hang guard, well above the run length
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            close_out();
        end
    end
endmodule // csr_router_tb_top

bind csr_router csr_router_monitor MON (.*);

// *** tb/csr_term_model.sv ***
// Purpose: Terminal side clock source
// Assumes: Terminal baud clock runs free
// Notes: Period shortened to 160 ns
`timescale 1ns/10ps
module csr_term_model (
    // Link clock
    output logic clk16
);
    // 16X clock, its edges fixed on falling edges of the system clock
    initial clk16 = 1'b0;
    always #80 clk16 = ~clk16;
endmodule // csr_term_model
